// [hw/bac_top.sv]
// Billboard activation control with AHB-Lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "bac_defs.svh"
module bac_top
    import bac_pkg::*;
#(
    parameter int unsigned TICK_CYC = `BAC_TICK_NS / `BAC_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [16:0] gpio_in,
    input wire logic host_addr_set,
    input wire logic alt_str_req,
    input wire logic desc_req,
    input wire logic [7:0] desc_idx,
    input wire logic [7:0] otp_rdata,
    input wire logic otp_rvalid,
    output logic func_attach,
    output logic bb_desc_sel,
    output logic otp_rd,
    output logic [12:0] otp_addr,
    output logic [7:0] desc_data,
    output logic desc_valid
);
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a[7:2] == off[7:2]);
    endfunction

    bac_state_e state_q, state_d;
    logic [7:0] ctrl_q;
    bac_tmr_t reload_q [2];
    logic [1:0] run_q;
    bac_tmr_t cnt_q [2];
    logic [1:0] expire_w;
    logic [1:0] start_w;
    logic [31:0] tick_cnt_q;
    logic tick_w;
    logic [7:0] disc_cnt_q;
    logic disc_done_w;
    logic armed_q;
    logic hreadyout_q, rd_pend_q, wr_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic attach_q, bb_sel_q, otp_rd_q, desc_valid_q;
    logic [12:0] otp_addr_q;
    logic [7:0] desc_data_q;

    // Failure pin selection; reserved and unlisted codes read as idle
    wire [4:0] sel_w = ctrl_q[`BAC_SEL_HI:`BAC_SEL_LO];
    wire sel_ok_w = (sel_w != `BAC_SEL_RSVD) && (sel_w <= `BAC_PIN_LAST);
    // Each pin has its own synchroniser so a select change never exposes a stale level
    wire [16:0] gpio_s_w;
    for (genvar p = 0; p < `BAC_NUM_PINS; p++) begin : g_sync
        bac_sync u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .d(gpio_in[p]),
            .q(gpio_s_w[p])
        );
    end
    wire pin_s_w = sel_ok_w ? gpio_s_w[sel_w] : 1'b1;
    wire fail_w = !pin_s_w;
    wire en_w = ctrl_q[`BAC_EN_BIT];

    // Bus slave: writes zero wait, reads one wait so a preceding write is seen
    wire take_w = hsel && htrans[1] && hready;
    wire wr_ctrl_w = wr_pend_q && is_reg(addr_q, `BAC_OFF_CTRL);
    wire wr_tmra_w = wr_pend_q && is_reg(addr_q, `BAC_OFF_TMRA);
    wire wr_tmrb_w = wr_pend_q && is_reg(addr_q, `BAC_OFF_TMRB);
    wire [31:0] stat_w = {25'h0000000, run_q, armed_q, fail_w, 1'b0, state_q};
    wire [31:0] rd_val_w =
        is_reg(addr_q, `BAC_OFF_CTRL) ? {24'h000000, ctrl_q} :
        is_reg(addr_q, `BAC_OFF_TMRA) ? {16'h0000, reload_q[0]} :
        is_reg(addr_q, `BAC_OFF_TMRB) ? {16'h0000, reload_q[1]} :
        is_reg(addr_q, `BAC_OFF_STAT) ? stat_w : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= take_w && hwrite;
            rd_pend_q <= take_w && !hwrite;
            if (take_w) begin
                addr_q <= haddr[7:0];
            end
            if (take_w && !hwrite) begin
                hreadyout_q <= 1'b0;
            end else if (rd_pend_q) begin
                hreadyout_q <= 1'b1;
                hrdata_q <= rd_val_w;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `BAC_CTRL_RST;
            reload_q[0] <= `BAC_TMR_RST;
            reload_q[1] <= `BAC_TMR_RST;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= hwdata[7:0] & `BAC_CTRL_WMASK;
            end
            if (wr_tmra_w) begin
                reload_q[0] <= hwdata[15:0];
            end
            if (wr_tmrb_w) begin
                reload_q[1] <= hwdata[15:0];
            end
        end
    end

    // 10 ms tick; timers and detach time count in ticks
    assign tick_w = (tick_cnt_q == 32'(TICK_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_w ? 32'h00000000 : tick_cnt_q + 32'h00000001;
        end
    end

    assign start_w[0] = (state_q == bac_st_bb) && host_addr_set;
    assign start_w[1] = (state_q == bac_st_bb) && alt_str_req;
    generate
        for (genvar i = 0; i < 2; i++) begin : g_tmr
            assign expire_w[i] = run_q[i] && tick_w && ((cnt_q[i] + 16'h0001) >= reload_q[i]);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    run_q[i] <= 1'b0;
                    cnt_q[i] <= 16'h0000;
                end else if (state_q != bac_st_bb) begin
                    run_q[i] <= 1'b0;
                    cnt_q[i] <= 16'h0000;
                end else if (start_w[i] && !run_q[i]) begin
                    run_q[i] <= 1'b1;
                    cnt_q[i] <= 16'h0000;
                end else if (run_q[i] && tick_w) begin
                    cnt_q[i] <= cnt_q[i] + 16'h0001;
                end
            end
        end
    endgenerate

    // Detach lasts a fixed number of ticks so the host sees a real unplug
    wire in_disc_w = (state_q == bac_st_disc_bb) || (state_q == bac_st_disc_std);
    assign disc_done_w = tick_w && (disc_cnt_q == `BAC_DISC_TICKS);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disc_cnt_q <= 8'h00;
        end else if (!in_disc_w) begin
            disc_cnt_q <= 8'h00;
        end else if (tick_w) begin
            disc_cnt_q <= disc_cnt_q + 8'h01;
        end
    end

    // Re-arm only once the failure has gone, otherwise expiry would loop forever
    wire activate_w = (state_q == bac_st_std) && en_w && fail_w && armed_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 1'b1;
        end else if (!fail_w) begin
            armed_q <= 1'b1;
        end else if (activate_w) begin
            armed_q <= 1'b0;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            bac_st_std: begin
                if (activate_w) begin
                    state_d = bac_st_disc_bb;
                end
            end
            bac_st_disc_bb: begin
                if (disc_done_w) begin
                    state_d = bac_st_bb;
                end
            end
            bac_st_bb: begin
                if ((|expire_w) || !fail_w || !en_w) begin
                    state_d = bac_st_disc_std;
                end
            end
            bac_st_disc_std: begin
                if (disc_done_w) begin
                    state_d = bac_st_std;
                end
            end
            default: state_d = bac_st_std;
        endcase
    end

    // Descriptor text and link come from one-time memory only in billboard mode
    wire fetch_w = (state_q == bac_st_bb) && desc_req;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= bac_st_std;
            attach_q <= 1'b1;
            bb_sel_q <= 1'b0;
            otp_rd_q <= 1'b0;
            otp_addr_q <= 13'h0000;
            desc_data_q <= 8'h00;
            desc_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            attach_q <= (state_d == bac_st_std) || (state_d == bac_st_bb);
            bb_sel_q <= (state_d == bac_st_bb);
            otp_rd_q <= fetch_w;
            if (fetch_w) begin
                otp_addr_q <= `BAC_MSG_BASE + {5'h00, desc_idx};
            end
            desc_valid_q <= otp_rvalid && bb_sel_q;
            if (otp_rvalid && bb_sel_q) begin
                desc_data_q <= otp_rdata;
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign func_attach = attach_q;
    assign bb_desc_sel = bb_sel_q;
    assign otp_rd = otp_rd_q;
    assign otp_addr = otp_addr_q;
    assign desc_data = desc_data_q;
    assign desc_valid = desc_valid_q;

    property p_rsvd_zero;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_q[7:6] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits set");

    property p_disabled;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == bac_st_std) && !en_w |=> (state_q == bac_st_std);
    endproperty
    a_disabled: assert property (p_disabled) else $error("activation while disabled");

    property p_activate;
        @(posedge hclk) disable iff (!hresetn)
        activate_w |=> (state_q == bac_st_disc_bb) && !func_attach;
    endproperty
    a_activate: assert property (p_activate) else $error("failure did not detach");

    property p_no_fail;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == bac_st_std) && pin_s_w |=> !bb_desc_sel;
    endproperty
    a_no_fail: assert property (p_no_fail) else $error("billboard without failure");

    property p_bb_attach;
        @(posedge hclk) disable iff (!hresetn)
        $rose(bb_desc_sel) |-> func_attach && $past(state_q == bac_st_disc_bb);
    endproperty
    a_bb_attach: assert property (p_bb_attach) else $error("billboard attach not after detach");

    property p_tmra;
        @(posedge hclk) disable iff (!hresetn)
        start_w[0] && !$past(host_addr_set) && (state_d == bac_st_bb) |=> run_q[0];
    endproperty
    a_tmra: assert property (p_tmra) else $error("timer A not started");

    property p_tmrb;
        @(posedge hclk) disable iff (!hresetn)
        start_w[1] && !run_q[1] && (state_d == bac_st_bb) |=> run_q[1] && (cnt_q[1] == 16'h0000);
    endproperty
    a_tmrb: assert property (p_tmrb) else $error("timer B not started");

    property p_expire;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == bac_st_bb) && (|expire_w) |=> !func_attach ##1 !bb_desc_sel;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry did not detach");

    property p_fetch;
        @(posedge hclk) disable iff (!hresetn)
        fetch_w |=> otp_rd && (otp_addr == `BAC_MSG_BASE + {5'h00, $past(desc_idx)});
    endproperty
    a_fetch: assert property (p_fetch) else $error("message fetch missing");
endmodule

// [shared/bac_defs.svh]
// Constants for the billboard activation control block
`ifndef BAC_DEFS_SVH
`define BAC_DEFS_SVH
`define BAC_OFF_CTRL 8'h04
`define BAC_OFF_TMRA 8'h08
`define BAC_OFF_TMRB 8'h0C
`define BAC_OFF_STAT 8'h10
`define BAC_CTRL_RST 8'h14
`define BAC_CTRL_WMASK 8'h3F
`define BAC_EN_BIT 0
`define BAC_SEL_HI 5
`define BAC_SEL_LO 1
`define BAC_SEL_RSVD 5'h09
`define BAC_NUM_PINS 17
`define BAC_PIN_LAST 5'h10
`define BAC_TMR_RST 16'h07D0
`define BAC_TICK_NS 10000000
`define BAC_CLK_NS 25
`define BAC_DISC_TICKS 8'h0A
`define BAC_MSG_BASE 13'h0100
`endif

// [shared/bac_pkg.sv]
// Types shared by the billboard activation control block
package bac_pkg;
    typedef enum logic [1:0] {
        bac_st_std = 2'b00,
        bac_st_disc_bb = 2'b01,
        bac_st_bb = 2'b10,
        bac_st_disc_std = 2'b11
    } bac_state_e;
    typedef logic [15:0] bac_tmr_t;
endpackage

// [hw/bac_sync.sv]
// Two-flop level synchroniser for the failure input
`timescale 1ns/100ps
module bac_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic q_q;

    // Idle level is high so reset never looks like a failure
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 1'b1;
            q_q <= 1'b1;
        end else begin
            meta_q <= d;
            q_q <= meta_q;
        end
    end
    assign q = q_q;

    property p_sync_lat;
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn, 2) |-> (q == $past(d, 2));
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("sync latency not two cycles");
endmodule

// [verif/bac_pd_model.sv]
// Model of the power delivery controller pins and the one-time memory read port
`timescale 1ns/100ps
module bac_pd_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [4:0] fail_pin,
    input wire logic fail_on,
    output logic [16:0] gpio_in,
    input wire logic otp_rd,
    input wire logic [12:0] otp_addr,
    output logic [7:0] otp_rdata,
    output logic otp_rvalid
);
    logic [1:0] pend_q;
    logic [12:0] addr_q;
    // Pins not pulled low sit at their pull-up level
    assign gpio_in = ~(17'(fail_on) << fail_pin);
    // Memory answers three cycles late; its data lines toggle while not valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 2'h0;
            addr_q <= 13'h0;
            otp_rvalid <= 1'b0;
            otp_rdata <= 8'h00;
        end else begin
            pend_q <= {pend_q[0], otp_rd};
            if (otp_rd) begin
                addr_q <= otp_addr;
            end
            otp_rvalid <= pend_q[1];
            otp_rdata <= pend_q[1] ? (addr_q[7:0] ^ 8'hA5) : ~otp_rdata;
        end
    end
endmodule

// [verif/bac_top_tb.sv]
// Self-checking bench for the billboard activation control block
`timescale 1ns/100ps
module bac_top_tb;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} bac_row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic host_addr_set = 1'b0;
    logic alt_str_req = 1'b0;
    logic desc_req = 1'b0;
    logic fail_on = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] desc_idx = 8'h00;
    logic [7:0] otp_rdata, desc_data;
    logic [4:0] fail_pin = 5'h00;
    logic [16:0] gpio_in;
    logic [12:0] otp_addr;
    logic hreadyout, hresp, otp_rvalid, func_attach, bb_desc_sel, otp_rd, desc_valid;
    int fails = 0;
    int tests_run = 0;
    // Unmapped 0x20 sits among the rows; timer reloads are shortened for the later sessions
    bac_row_s rows [10] = '{'{1'b0, 8'h04, 32'h0, 32'h14}, '{1'b0, 8'h08, 32'h0, 32'h7D0},
        '{1'b0, 8'h0C, 32'h0, 32'h7D0}, '{1'b1, 8'h04, 32'hFF, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h3F},
        '{1'b1, 8'h20, 32'h5A, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h08, 32'h3, 32'h0},
        '{1'b1, 8'h0C, 32'h2, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h3}};
    always #12.5 hclk = ~hclk;
    bac_top #(.TICK_CYC(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .gpio_in, .host_addr_set, .alt_str_req,
        .desc_req, .desc_idx, .otp_rdata, .otp_rvalid, .func_attach, .bb_desc_sel, .otp_rd,
        .otp_addr, .desc_data, .desc_valid);
    bac_pd_model pd (.hclk, .hresetn, .fail_pin, .fail_on, .gpio_in, .otp_rd, .otp_addr, .otp_rdata,
        .otp_rvalid);
    task automatic test_done();
        $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop(input string s);
        fails++;
        $display("Error at %0t: %s wait timed out", $time, s);
        test_done();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Master holds each phase until hready is sampled high
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        for (int p = 0; p < 2; p++) begin
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 40);
            if (p == 0) begin
                htrans <= 2'h0;
                hwdata <= d;
            end
        end
        r = hrdata;
        if (n >= 40) begin
            stop("bus");
        end
    endtask
    // k selects attach, memory read strobe or descriptor valid
    task automatic wait_sig(input int k, input logic v);
        int n;
        n = 0;
        while ((k == 0 ? func_attach : k == 1 ? otp_rd : desc_valid) !== v && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 2000) begin
            stop("signal");
        end
    endtask
    task automatic session();
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
    endtask
    initial begin
        idle(3);
        chk(32'(func_attach), 32'h1);
        chk(32'(bb_desc_sel), 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            ahb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(r, rows[i].e);
            chk(32'(hresp), 32'h0);
        end
        $display("Test registers done");
        ahb(1'b1, 8'h04, 32'h14);
        fail_pin <= 5'h0A;
        fail_on <= 1'b1;
        idle(100);
        chk(32'(func_attach), 32'h1);
        ahb(1'b1, 8'h04, 32'h13);
        fail_pin <= 5'h09;
        idle(100);
        chk(32'(func_attach), 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk(32'(r[3:0]), 32'h0);
        $display("Test disabled and reserved done");
        fail_pin <= 5'h0A;
        ahb(1'b1, 8'h04, 32'h15);
        session();
        chk(32'(bb_desc_sel), 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk(32'(r[1:0]), 32'h2);
        desc_idx <= 8'h05;
        desc_req <= 1'b1;
        @(posedge hclk);
        desc_req <= 1'b0;
        wait_sig(1, 1'b1);
        chk(32'(otp_addr), 32'h105);
        wait_sig(2, 1'b1);
        chk(32'(desc_data), 32'hA0);
        host_addr_set <= 1'b1;
        @(posedge hclk);
        host_addr_set <= 1'b0;
        session();
        chk(32'(bb_desc_sel), 32'h0);
        idle(100);
        chk(32'(func_attach), 32'h1);
        $display("Test first session done");
        fail_on <= 1'b0;
        idle(20);
        fail_pin <= 5'h10;
        ahb(1'b1, 8'h04, 32'h21);
        fail_on <= 1'b1;
        session();
        chk(32'(bb_desc_sel), 32'h1);
        alt_str_req <= 1'b1;
        @(posedge hclk);
        alt_str_req <= 1'b0;
        session();
        chk(32'(bb_desc_sel), 32'h0);
        $display("Test second session done");
        hresetn <= 1'b0;
        idle(2);
        chk(32'(func_attach), 32'h1);
        chk(32'(bb_desc_sel), 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h14);
        ahb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h7D0);
        $display("Test reset done");
        test_done();
    end
endmodule
